// File: core/sspc_pkg.sv
// Purpose: shared constants and types of the standby sleep power control block
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes: printed offsets are indices; byte address is four times the index
package sspc_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] SLEEP_CFG_IDX = 8'h01;
   localparam logic [7:0] STDBY_CFG_IDX = 8'h08;
   localparam logic [7:0] PWR_STAT_IDX = 8'h09;
   localparam logic [7:0] SLEEP_CFG_RST = 8'h00;
   localparam logic [15:0] STDBY_CFG_RST = 16'h0400;
   localparam logic [15:0] STDBY_CFG_WMASK = 16'h04C0;
   // ----------------------------------------------------------------
   // fields
   // ----------------------------------------------------------------
   localparam int SLEEP_DEPTH_LSB = 0;
   localparam int BACK_BIAS_BIT = 10;
   localparam int REG_SEL_LSB = 6;
   localparam logic [2:0] DEPTH_IDLE = 3'h2;
   localparam logic [2:0] DEPTH_STANDBY = 3'h4;
   localparam logic [1:0] REG_AUTO = 2'h0;
   localparam logic [1:0] REG_MAIN = 2'h1;
   localparam logic [1:0] REG_LOW = 2'h2;

   typedef enum logic [1:0] {
      SSPC_ACTIVE = 2'b00,
      SSPC_IDLE = 2'b01,
      SSPC_STANDBY = 2'b11
   } sspc_state_t;

   typedef struct packed {
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] haddr;
   } sspc_ahb_req_t;

   typedef struct packed {
      logic [2:0] sleep_depth_sel;
      logic [1:0] regulator_standby_sel;
      logic sram_back_bias;
   } sspc_cfg_t;
endpackage : sspc_pkg

// File: core/sspc_top.sv
// Purpose: standby sleep power control, sleep decode, clock wake and supply select
// Assumes: core signals and peripheral requests are synchronous to CLK_SYS
// Notes: single AHB-Lite slave, zero wait states, OKAY response always
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
module sspc_top #(
   parameter int N_GEN = 9,
   parameter int N_PERIPH = 8
) (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic WAIT_FOR_IRQ_INSTR,
   input wire logic HANDLER_EXIT_LOWEST,
   input wire logic SLEEP_AFTER_HANDLER,
   input wire logic ASYNC_IRQ_WAKE,
   input wire logic SYNC_IRQ_WAKE,
   input wire logic WRITE_GUARD,
   input wire logic [N_GEN-1:0] GEN_KEEP_RUNNING_IN_STANDBY,
   input wire logic [N_GEN-1:0] GEN_CLOCK_ON_REQUEST,
   input wire logic [N_PERIPH-1:0] PERIPH_GENERIC_CLOCK_REQ,
   input wire logic [N_PERIPH-1:0] PERIPH_BUSCLK_REQ,
   input wire logic [N_PERIPH*4-1:0] PERIPH_GEN_SEL,
   output logic CPU_CLK_EN,
   output logic [N_GEN-1:0] GEN_CLK_EN,
   output logic [N_PERIPH-1:0] BUS_CLK_EN,
   output logic MAIN_CLK_EN,
   output logic MAIN_REG_SEL,
   output logic SRAM_BACK_BIASED,
   output logic DMA_SRAM_ALLOW,
   output logic CPU_WAKE,
   output logic [1:0] POWER_STATE
);
   import sspc_pkg::*;

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   logic wr_pend_ff;
   logic [7:0] wr_idx_ff;
   logic [7:0] rd_idx;
   logic [31:0] nxt_rdata;
   logic addr_phase;
   sspc_cfg_t cfg_ff;
   sspc_state_t state_ff;
   sspc_state_t nxt_state;
   logic sleepwalk;

   function automatic logic depth_known(input logic [2:0] d);
      depth_known = (d == DEPTH_IDLE) || (d == DEPTH_STANDBY);
   endfunction : depth_known

   assign addr_phase = HSEL && HREADY && HTRANS[1];
   assign rd_idx = HADDR[9:2];
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

   // write address phase remembered for its data phase
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         wr_pend_ff <= 1'b0;
      else
         wr_pend_ff <= addr_phase && HWRITE;
   end

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         wr_idx_ff <= 8'h00;
      else
         wr_idx_ff <= rd_idx;
   end

   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      case (rd_idx)
         SLEEP_CFG_IDX: nxt_rdata[2:0] = cfg_ff.sleep_depth_sel;
         STDBY_CFG_IDX:
         begin
            nxt_rdata[REG_SEL_LSB +: 2] = cfg_ff.regulator_standby_sel;
            nxt_rdata[BACK_BIAS_BIT] = cfg_ff.sram_back_bias;
         end
         PWR_STAT_IDX:
         begin
            nxt_rdata[1:0] = state_ff;
            nxt_rdata[2] = MAIN_REG_SEL;
            nxt_rdata[3] = SRAM_BACK_BIASED;
         end
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         HRDATA <= 32'h0000_0000;
      else if (addr_phase && !HWRITE)
         HRDATA <= nxt_rdata;
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   // writes land one cycle after the address phase; software reads back
   // before sleeping, so no bypass is needed
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
      begin
         cfg_ff.sleep_depth_sel <= SLEEP_CFG_RST[2:0];
         cfg_ff.regulator_standby_sel <= STDBY_CFG_RST[REG_SEL_LSB +: 2];
         cfg_ff.sram_back_bias <= STDBY_CFG_RST[BACK_BIAS_BIT];
      end
      else if (wr_pend_ff && !WRITE_GUARD)
      begin
         if (wr_idx_ff == SLEEP_CFG_IDX)
            cfg_ff.sleep_depth_sel <= HWDATA[SLEEP_DEPTH_LSB +: 3];
         else if (wr_idx_ff == STDBY_CFG_IDX)
         begin
            cfg_ff.regulator_standby_sel <= HWDATA[REG_SEL_LSB +: 2];
            cfg_ff.sram_back_bias <= HWDATA[BACK_BIAS_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // sleep state machine
   // ----------------------------------------------------------------
   logic sleep_req;
   assign sleep_req = WAIT_FOR_IRQ_INSTR
      || (HANDLER_EXIT_LOWEST && SLEEP_AFTER_HANDLER);

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         SSPC_ACTIVE:
            // reserved depth codes keep the core running
            if (sleep_req && depth_known(cfg_ff.sleep_depth_sel))
               nxt_state = (cfg_ff.sleep_depth_sel == DEPTH_STANDBY)
                  ? SSPC_STANDBY : SSPC_IDLE;
         SSPC_IDLE:
            if (ASYNC_IRQ_WAKE || SYNC_IRQ_WAKE)
               nxt_state = SSPC_ACTIVE;
         SSPC_STANDBY:
            // only requested bus clocks run, so sync irqs come from requesting peripherals
            if (ASYNC_IRQ_WAKE || SYNC_IRQ_WAKE)
               nxt_state = SSPC_ACTIVE;
         default: nxt_state = SSPC_ACTIVE;
      endcase
   end

   // state held in flops that never reset except at power-on
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         state_ff <= SSPC_ACTIVE;
      else
         state_ff <= nxt_state;
   end

   // one-cycle wake pulse; the core picks handler or resume by its mask
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         CPU_WAKE <= 1'b0;
      else
         CPU_WAKE <= (state_ff != SSPC_ACTIVE) && (nxt_state == SSPC_ACTIVE);
   end

   // ----------------------------------------------------------------
   // clock gating
   // ----------------------------------------------------------------
   logic [N_GEN-1:0] gen_req;
   logic bus_req;
   always_comb
   begin
      gen_req = '0;
      for (int i = 0; i < N_PERIPH; i++)
         if (PERIPH_GENERIC_CLOCK_REQ[i])
            gen_req[PERIPH_GEN_SEL[i*4 +: 4]] = 1'b1;
   end
   assign bus_req = |PERIPH_BUSCLK_REQ;
   assign sleepwalk = |gen_req || bus_req;

   logic in_stdby;
   assign in_stdby = (state_ff == SSPC_STANDBY);

   // ----------------------------------------------------------------
   // cpu and main clock
   // ----------------------------------------------------------------
   // the cpu clock stops in every sleep depth; logic state is kept
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         CPU_CLK_EN <= 1'b1;
      else
         CPU_CLK_EN <= (state_ff == SSPC_ACTIVE);
   end

   // in standby the main unit wakes only for a bus clock request
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         MAIN_CLK_EN <= 1'b1;
      else
         MAIN_CLK_EN <= !in_stdby || bus_req;
   end

   // ----------------------------------------------------------------
   // generator enables
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         GEN_CLK_EN <= '1;
      else
      begin
         for (int g = 0; g < N_GEN; g++)
            // stop, run throughout, or follow requests
            GEN_CLK_EN[g] <= !in_stdby || (GEN_KEEP_RUNNING_IN_STANDBY[g]
               && (!GEN_CLOCK_ON_REQUEST[g] || gen_req[g]
               || (g == 0 && bus_req)));
      end
   end

   // ----------------------------------------------------------------
   // bus clock enables
   // ----------------------------------------------------------------
   // idle and standby both gate unrequested bus clocks at the main unit
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         BUS_CLK_EN <= '1;
      else
         BUS_CLK_EN <= (state_ff == SSPC_ACTIVE) ? '1 : PERIPH_BUSCLK_REQ;
   end

   // ----------------------------------------------------------------
   // regulator select
   // ----------------------------------------------------------------
   // reserved regulator code falls back to auto, the reset behaviour
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         MAIN_REG_SEL <= 1'b1;
      else if (!in_stdby)
         MAIN_REG_SEL <= 1'b1;
      else if (cfg_ff.regulator_standby_sel == REG_MAIN)
         MAIN_REG_SEL <= 1'b1;
      else if (cfg_ff.regulator_standby_sel == REG_LOW)
         MAIN_REG_SEL <= 1'b0;
      else
         MAIN_REG_SEL <= sleepwalk;
   end

   // ----------------------------------------------------------------
   // sram bias and dma access
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         SRAM_BACK_BIASED <= 1'b0;
      else
         SRAM_BACK_BIASED <= in_stdby && cfg_ff.sram_back_bias;
   end

   // same term as the bias flop, so dma never sees a biased sram
   always_ff @(posedge CLK_SYS or posedge RST)
   begin
      if (RST)
         DMA_SRAM_ALLOW <= 1'b1;
      else
         DMA_SRAM_ALLOW <= !(in_stdby && cfg_ff.sram_back_bias);
   end

   assign POWER_STATE = state_ff;
endmodule : sspc_top

// File: dv/sspc_chk.sv
// Purpose: port checker of the sleep control block
// Assumes: one clock domain, inputs synchronous
// Notes: bound to the top module below
`timescale 1ns/100ps
module sspc_chk #(
   parameter int N_PERIPH = 8
) (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic WAIT_FOR_IRQ_INSTR,
   input wire logic HANDLER_EXIT_LOWEST,
   input wire logic SLEEP_AFTER_HANDLER,
   input wire logic ASYNC_IRQ_WAKE,
   input wire logic [N_PERIPH-1:0] PERIPH_BUSCLK_REQ,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic CPU_CLK_EN,
   input wire logic [N_PERIPH-1:0] BUS_CLK_EN,
   input wire logic MAIN_CLK_EN,
   input wire logic MAIN_REG_SEL,
   input wire logic SRAM_BACK_BIASED,
   input wire logic DMA_SRAM_ALLOW,
   input wire logic CPU_WAKE,
   input wire logic [1:0] POWER_STATE
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   sequence s_stby_irq;
      POWER_STATE == 2'h3 ##0 ASYNC_IRQ_WAKE;
   endsequence
   stby_cause_a: assert property (POWER_STATE == 2'h3 && $past(POWER_STATE) == 2'h0
      |-> $past(WAIT_FOR_IRQ_INSTR || HANDLER_EXIT_LOWEST && SLEEP_AFTER_HANDLER))
      else $error("standby without request");
   irq_wake_a: assert property (s_stby_irq |=> POWER_STATE == 2'h0 && CPU_WAKE)
      else $error("no wake on irq");
   wake_pulse_a: assert property (CPU_WAKE |=> !CPU_WAKE)
      else $error("wake pulse too long");
   dma_gate_a: assert property (DMA_SRAM_ALLOW != SRAM_BACK_BIASED)
      else $error("dma access while biased");
   awake_supply_a: assert property ((POWER_STATE != 2'h3)[*2]
      |-> MAIN_REG_SEL && !SRAM_BACK_BIASED) else $error("awake supply wrong");
   cpu_stop_a: assert property (POWER_STATE == 2'h3 |=> !CPU_CLK_EN)
      else $error("cpu clock in standby");
   bus_gate_a: assert property ($past(POWER_STATE) == 2'h3
      |-> BUS_CLK_EN == $past(PERIPH_BUSCLK_REQ) && MAIN_CLK_EN == |$past(PERIPH_BUSCLK_REQ))
      else $error("bus clock gating wrong");
   bus_live_a: assert property (HREADYOUT && !HRESP)
      else $error("bus not answering");
endmodule : sspc_chk
bind sspc_top sspc_chk #(.N_PERIPH(N_PERIPH)) u_sspc_chk (.*);

// File: dv/sspc_core_model.sv
// Purpose: processor core model, bus master and wait-for-irq
// Assumes: zero or more wait states
// Notes: only single word transfers
`timescale 1ns/100ps
module sspc_core_model (
   input wire logic clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   output logic wait_for_irq_instr
);
   import sspc_pkg::*;
   initial
   begin
      {hsel, haddr, htrans, hwrite, hwdata, wait_for_irq_instr} = '0;
      hsize = 3'h2;
   end
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'h0};
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic sleep_req(input logic [2:0] d);
      logic [31:0] r;
      bus(1'b1, SLEEP_CFG_IDX, {29'h0, d}, r);
      // bridge latency: confirm the write landed first
      do bus(1'b0, SLEEP_CFG_IDX, 32'h0, r); while (r[2:0] !== d);
      @(posedge clk);
      wait_for_irq_instr <= 1'b1;
      @(posedge clk);
      wait_for_irq_instr <= 1'b0;
   endtask : sleep_req
endmodule : sspc_core_model

// File: dv/sspc_tb.sv
// Purpose: self-checking bench of the sleep control block
// Assumes: zero-wait bus slave
// Notes: core model drives bus and wait-for-irq
`timescale 1ns/100ps
module sspc_tb;
   import sspc_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic hsel, hwrite, hreadyout, hresp, wait_for_irq_instr, cpu_clk_en;
   logic main_clk_en, mreg, sram_bb, dma_ok, wk;
   logic hexit = 1'b0, sah = 1'b0, a_irq = 1'b0, s_irq = 1'b0, guard = 1'b0;
   logic [1:0] htrans, pst;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [31:0] gsel = 32'h7654_3210;
   logic [8:0] keep = 9'h000, onreq = 9'h000, gen_en;
   logic [7:0] gen_clk_req = 8'h00, bus_req = 8'h00, bus_en;
   int num_errors = 0, compares = 0, cyc = 0;
   sspc_top u_sspc_top (.CLK_SYS(clk_sys), .RST(rst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
      .WAIT_FOR_IRQ_INSTR(wait_for_irq_instr),
      .HANDLER_EXIT_LOWEST(hexit), .SLEEP_AFTER_HANDLER(sah), .ASYNC_IRQ_WAKE(a_irq),
      .SYNC_IRQ_WAKE(s_irq), .WRITE_GUARD(guard), .GEN_KEEP_RUNNING_IN_STANDBY(keep),
      .GEN_CLOCK_ON_REQUEST(onreq), .PERIPH_GENERIC_CLOCK_REQ(gen_clk_req),
      .PERIPH_BUSCLK_REQ(bus_req),
      .PERIPH_GEN_SEL(gsel), .CPU_CLK_EN(cpu_clk_en), .GEN_CLK_EN(gen_en), .BUS_CLK_EN(bus_en),
      .MAIN_CLK_EN(main_clk_en), .MAIN_REG_SEL(mreg), .SRAM_BACK_BIASED(sram_bb),
      .DMA_SRAM_ALLOW(dma_ok), .CPU_WAKE(wk), .POWER_STATE(pst));
   sspc_core_model u_sspc_core_model (.clk(clk_sys), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .wait_for_irq_instr(wait_for_irq_instr));
   initial forever #2 clk_sys = ~clk_sys;
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task test_done;
      if (num_errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   task step;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask : step
   task wake(input logic asy);
      @(posedge clk_sys);
      a_irq <= asy;
      s_irq <= !asy;
      @(posedge clk_sys);
      #1;
      chk("state", 32'(pst), 32'(SSPC_ACTIVE));
      chk("wake", 32'(wk), 32'h1);
      @(posedge clk_sys);
      {a_irq, s_irq, bus_req, gen_clk_req} <= '0;
   endtask : wake
   task t_regs;
      u_sspc_core_model.bus(1'b0, STDBY_CFG_IDX, 32'h0, rd);
      chk("stdby", rd, 32'(STDBY_CFG_RST));
      u_sspc_core_model.bus(1'b0, SLEEP_CFG_IDX, 32'h0, rd);
      chk("sleep", rd, 32'(SLEEP_CFG_RST));
      u_sspc_core_model.bus(1'b0, 8'h00, 32'h0, rd);
      chk("unmapped", rd, 32'h0);
      guard <= 1'b1;
      u_sspc_core_model.bus(1'b1, STDBY_CFG_IDX, 32'h0, rd);
      guard <= 1'b0;
      u_sspc_core_model.bus(1'b0, STDBY_CFG_IDX, 32'h0, rd);
      chk("guarded", rd, 32'(STDBY_CFG_RST));
      u_sspc_core_model.bus(1'b1, STDBY_CFG_IDX, 32'hFFFF_FFFF, rd);
      u_sspc_core_model.bus(1'b0, STDBY_CFG_IDX, 32'h0, rd);
      chk("fields", rd, 32'(STDBY_CFG_WMASK));
   endtask : t_regs
   task t_modes;
      for (int i = 0; i < 8; i++)
      begin
         u_sspc_core_model.bus(1'b1, STDBY_CFG_IDX, {21'h0, i[2], 2'h0, i[1:0], 6'h0}, rd);
         u_sspc_core_model.sleep_req(DEPTH_STANDBY);
         step();
         chk("state", 32'(pst), 32'(SSPC_STANDBY));
         chk("regulator", 32'(mreg), 32'(i[1:0] == REG_MAIN));
         chk("bias", 32'(sram_bb), 32'(i[2]));
         chk("dma", 32'(dma_ok), 32'(!i[2]));
         wake(1'b1);
      end
   endtask : t_modes
   task t_walk;
      // tick overflow irq assumed on: back-bias cleared before standby
      u_sspc_core_model.bus(1'b1, STDBY_CFG_IDX, 32'h0, rd);
      keep <= 9'h009;
      onreq <= 9'h009;
      u_sspc_core_model.sleep_req(DEPTH_STANDBY);
      step();
      chk("gen", 32'(gen_en), 32'h0);
      chk("regulator", 32'(mreg), 32'h0);
      @(posedge clk_sys);
      bus_req <= 8'h04;
      gen_clk_req <= 8'h08;
      step();
      chk("gen", 32'(gen_en), 32'h009);
      chk("bus", 32'(bus_en), 32'h04);
      chk("main", 32'(main_clk_en), 32'h1);
      chk("regulator", 32'(mreg), 32'h1);
      chk("cpu clk", 32'(cpu_clk_en), 32'h0);
      // status: standby state, main regulator on, sram not biased
      u_sspc_core_model.bus(1'b0, PWR_STAT_IDX, 32'h0, rd);
      chk("status", rd, 32'h0000_0007);
      wake(1'b1);
   endtask : t_walk
   task t_other;
      u_sspc_core_model.sleep_req(DEPTH_IDLE);
      step();
      chk("state", 32'(pst), 32'(SSPC_IDLE));
      chk("regulator", 32'(mreg), 32'h1);
      wake(1'b0);
      u_sspc_core_model.sleep_req(3'h3);
      step();
      chk("state", 32'(pst), 32'(SSPC_ACTIVE));
      u_sspc_core_model.bus(1'b1, SLEEP_CFG_IDX, 32'h4, rd);
      sah <= 1'b1;
      hexit <= 1'b1;
      @(posedge clk_sys);
      hexit <= 1'b0;
      step();
      chk("state", 32'(pst), 32'(SSPC_STANDBY));
      wake(1'b1);
   endtask : t_other
   initial
   begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      t_regs();
      t_modes();
      t_walk();
      t_other();
      test_done();
   end
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         num_errors++;
         test_done();
      end
   end
endmodule : sspc_tb
